// [hw/fpm_pkg.sv]
package fpm_pkg;

   // ----------------------------------------------------------------
   // Display modes in menu order
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      FPM_MODE_STATUS = 4'h0,
      FPM_MODE_TUNE   = 4'h1,
      FPM_MODE_DIAG   = 4'h2,
      FPM_MODE_ALARM  = 4'h3,
      FPM_MODE_PTABLE = 4'h4,
      FPM_MODE_BASIC  = 4'h5,
      FPM_MODE_GAIN   = 4'h6,
      FPM_MODE_EXT    = 4'h7,
      FPM_MODE_IO     = 4'h8,
      FPM_MODE_EXT2   = 4'h9,
      FPM_MODE_EXT3   = 4'hA,
      FPM_MODE_POS    = 4'hB
   } fpm_mode_e;

   // Control methods
   localparam logic [1:0] FPM_CTRL_PTABLE  = 2'h0;
   localparam logic [1:0] FPM_CTRL_PROGRAM = 2'h1;
   localparam logic [1:0] FPM_CTRL_OTHER   = 2'h2;

   // ----------------------------------------------------------------
   // Power-on sequence states (Gray along the path)
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FPM_PO_AXIS   = 2'b00,
      FPM_PO_SYMBOL = 2'b01,
      FPM_PO_RUN    = 2'b11
   } fpm_po_e;

   // Alarm views
   localparam logic [1:0] FPM_ALM_CURRENT = 2'h0;
   localparam logic [1:0] FPM_ALM_HISTORY = 2'h1;
   localparam logic [1:0] FPM_ALM_PARERR  = 2'h2;
   localparam logic [1:0] FPM_ALM_VIEWS   = 2'h3;

   // Timing
   localparam int unsigned FPM_CLK_HZ       = 20_000_000;
   localparam int unsigned FPM_SYMBOL_MS    = 2000;
   localparam int unsigned FPM_SYMBOL_CYC   = FPM_CLK_HZ / 1000 * FPM_SYMBOL_MS;
   localparam int unsigned FPM_AXIS_MS      = 2000;
   localparam int unsigned FPM_AXIS_CYC     = FPM_CLK_HZ / 1000 * FPM_AXIS_MS;
   localparam int unsigned FPM_DEBOUNCE_MS  = 10;
   localparam int unsigned FPM_DEBOUNCE_CYC = FPM_CLK_HZ / 1000 * FPM_DEBOUNCE_MS;

   // Reset values and display size
   localparam logic [4:0] FPM_ITEM_RST = 5'h00;
   localparam int unsigned FPM_DIGITS  = 5;
   localparam int unsigned FPM_SEGS    = 7;

endpackage

// [hw/fpm_debounce.sv]
module fpm_debounce #(
   parameter int unsigned STABLE_CYC = 200000
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic btn_i,
   output logic      press_o
);

   localparam int unsigned CW = $clog2(STABLE_CYC + 1);

   initial begin
      if (STABLE_CYC < 1) begin
         $error("STABLE_CYC must be at least 1");
      end
   end

   logic          s1_q;
   logic          s2_q;
   logic          lvl_q;
   logic          lvl_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          press_q;
   logic          press_d;

   // Two-stage synchroniser; only s2_q is looked at
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= btn_i;
         s2_q <= s1_q;
      end
   end

   always_comb begin
      lvl_d   = lvl_q;
      cnt_d   = '0;
      press_d = 1'b0;
      if (s2_q != lvl_q) begin
         cnt_d = cnt_q + CW'(1);
         if (cnt_q == CW'(STABLE_CYC - 1)) begin
            lvl_d   = s2_q;
            cnt_d   = '0;
            press_d = s2_q;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lvl_q   <= 1'b0;
         cnt_q   <= '0;
         press_q <= 1'b0;
      end else begin
         lvl_q   <= lvl_d;
         cnt_q   <= cnt_d;
         press_q <= press_d;
      end
   end

   assign press_o = press_q;

   one_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      press_o |=> !press_o) else $error("press pulse longer than one cycle");

endmodule

// [hw/fpm_menu.sv]
// Notes on behaviour
// - Mode button steps twelve modes in order
// - Point table mode only under point table
// - Table or program method starts in status
// - Configured axis name shown first at power-on
// - Drive all five seven-segment digits
// - Up/down move to adjacent status item
// - Selected item shows its symbol
// - Set button switches symbol to value
// - Power-on: parameter item symbol 2 s, then value
// - Alarm mode offers three views
module fpm_menu #(
   parameter int unsigned ITEMS        = 12,
   parameter int unsigned SYMBOL_CYC   = fpm_pkg::FPM_SYMBOL_CYC,
   parameter int unsigned AXIS_CYC     = fpm_pkg::FPM_AXIS_CYC,
   parameter int unsigned DEBOUNCE_CYC = fpm_pkg::FPM_DEBOUNCE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        btn_mode_i,
   input  wire logic        btn_up_i,
   input  wire logic        btn_down_i,
   input  wire logic        btn_set_i,
   input  wire logic [1:0]  ctrl_method_i,
   input  wire logic        axis_name_set_i,
   input  wire logic [4:0]  power_on_status_item_param_i,
   input  wire logic [34:0] axis_segs_i,
   input  wire logic [34:0] symbol_segs_i,
   input  wire logic [34:0] value_segs_i,
   input  wire logic [34:0] mode_segs_i,
   output logic [3:0]       mode_o,
   output logic [4:0]       item_o,
   output logic             show_value_o,
   output logic             show_axis_o,
   output logic [1:0]       alarm_view_o,
   output logic [34:0]      segs_o
);

   localparam int unsigned TW = $clog2((SYMBOL_CYC > AXIS_CYC ? SYMBOL_CYC : AXIS_CYC) + 1);

   initial begin
      if (ITEMS < 2 || ITEMS > 32) begin
         $error("ITEMS must lie in 2..32");
      end
      if (SYMBOL_CYC < 1 || AXIS_CYC < 1) begin
         $error("display times must be at least one cycle");
      end
   end

   // ----------------------------------------------------------------
   // Button conditioning
   // ----------------------------------------------------------------
   logic [3:0] raw;
   logic [3:0] press;
   assign raw = {btn_set_i, btn_down_i, btn_up_i, btn_mode_i};

   for (genvar g = 0; g < 4; g++) begin : g_btn
      fpm_debounce #(
         .STABLE_CYC (DEBOUNCE_CYC)
      ) u_db (
         .clk_i   (clk_i),
         .rstn_i  (rstn_i),
         .btn_i   (raw[g]),
         .press_o (press[g])
      );
   end

   logic p_mode;
   logic p_up;
   logic p_down;
   logic p_set;
   assign p_mode = press[0];
   assign p_up   = press[1];
   assign p_down = press[2];
   assign p_set  = press[3];

   // Control method and axis flag are static strap-like levels from off-chip
   logic [1:0] ctrl_s1_q;
   logic [1:0] ctrl_s2_q;
   logic       axis_s1_q;
   logic       axis_s2_q;
   logic [4:0] poi_s1_q;
   logic [4:0] poi_s2_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_s1_q <= 2'h0;
         ctrl_s2_q <= 2'h0;
         axis_s1_q <= 1'b0;
         axis_s2_q <= 1'b0;
         poi_s1_q  <= 5'h00;
         poi_s2_q  <= 5'h00;
      end else begin
         ctrl_s1_q <= ctrl_method_i;
         ctrl_s2_q <= ctrl_s1_q;
         axis_s1_q <= axis_name_set_i;
         axis_s2_q <= axis_s1_q;
         poi_s1_q  <= power_on_status_item_param_i;
         poi_s2_q  <= poi_s1_q;
      end
   end

   logic ptable_on;
   assign ptable_on = (ctrl_s2_q == fpm_pkg::FPM_CTRL_PTABLE);

   // ----------------------------------------------------------------
   // Power-on sequence
   // ----------------------------------------------------------------
   // Two settle cycles let the synchronised straps become valid first
   fpm_pkg::fpm_po_e po_q;
   fpm_pkg::fpm_po_e po_d;
   logic [TW-1:0]    tmr_q;
   logic [TW-1:0]    tmr_d;
   logic [1:0]       settle_q;
   logic [1:0]       settle_d;

   always_comb begin
      po_d     = po_q;
      tmr_d    = tmr_q;
      settle_d = settle_q;
      if (settle_q != 2'h3) begin
         settle_d = settle_q + 2'h1;
         tmr_d    = '0;
         if (settle_q == 2'h2 && !axis_s2_q) begin
            po_d = fpm_pkg::FPM_PO_SYMBOL;
         end
      end else begin
         case (po_q)
            fpm_pkg::FPM_PO_AXIS: begin
               tmr_d = tmr_q + TW'(1);
               if (tmr_q == TW'(AXIS_CYC - 1)) begin
                  po_d  = fpm_pkg::FPM_PO_SYMBOL;
                  tmr_d = '0;
               end
            end
            fpm_pkg::FPM_PO_SYMBOL: begin
               tmr_d = tmr_q + TW'(1);
               if (tmr_q == TW'(SYMBOL_CYC - 1)) begin
                  po_d  = fpm_pkg::FPM_PO_RUN;
                  tmr_d = '0;
               end
            end
            fpm_pkg::FPM_PO_RUN: begin
               tmr_d = '0;
            end
            default: begin
               po_d = fpm_pkg::FPM_PO_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         po_q     <= fpm_pkg::FPM_PO_AXIS;
         tmr_q    <= '0;
         settle_q <= 2'h0;
      end else begin
         po_q     <= po_d;
         tmr_q    <= tmr_d;
         settle_q <= settle_d;
      end
   end

   logic booting;
   assign booting = (po_q != fpm_pkg::FPM_PO_RUN);

   // ----------------------------------------------------------------
   // Menu state
   // ----------------------------------------------------------------
   // Buttons are ignored until the power-on sequence is over
   fpm_pkg::fpm_mode_e mode_q;
   fpm_pkg::fpm_mode_e mode_d;
   logic [4:0]         item_q;
   logic [4:0]         item_d;
   logic               val_q;
   logic               val_d;
   logic [1:0]         alm_q;
   logic [1:0]         alm_d;

   always_comb begin
      mode_d = mode_q;
      item_d = item_q;
      val_d  = val_q;
      alm_d  = alm_q;
      if (settle_q == 2'h2) begin
         mode_d = fpm_pkg::FPM_MODE_STATUS;
         item_d = (32'(poi_s2_q) < ITEMS) ? poi_s2_q : fpm_pkg::FPM_ITEM_RST;
         val_d  = 1'b0;
      end else if (po_q == fpm_pkg::FPM_PO_SYMBOL && po_d == fpm_pkg::FPM_PO_RUN) begin
         val_d = 1'b1;
      end else if (!booting) begin
         if (p_mode) begin
            val_d = 1'b0;
            alm_d = fpm_pkg::FPM_ALM_CURRENT;
            case (mode_q)
               fpm_pkg::FPM_MODE_ALARM: begin
                  mode_d = ptable_on ? fpm_pkg::FPM_MODE_PTABLE
                                     : fpm_pkg::FPM_MODE_BASIC;
               end
               fpm_pkg::FPM_MODE_POS: begin
                  mode_d = fpm_pkg::FPM_MODE_STATUS;
               end
               default: begin
                  mode_d = fpm_pkg::fpm_mode_e'(mode_q + 4'h1);
               end
            endcase
         end else if (mode_q == fpm_pkg::FPM_MODE_STATUS) begin
            if (p_up) begin
               item_d = (item_q == 5'(ITEMS - 1)) ? 5'h00 : item_q + 5'h01;
               val_d  = 1'b0;
            end else if (p_down) begin
               item_d = (item_q == 5'h00) ? 5'(ITEMS - 1) : item_q - 5'h01;
               val_d  = 1'b0;
            end else if (p_set) begin
               val_d = 1'b1;
            end
         end else if (mode_q == fpm_pkg::FPM_MODE_ALARM) begin
            if (p_up) begin
               alm_d = (alm_q == fpm_pkg::FPM_ALM_PARERR) ? fpm_pkg::FPM_ALM_CURRENT
                                                          : alm_q + 2'h1;
            end else if (p_down) begin
               alm_d = (alm_q == fpm_pkg::FPM_ALM_CURRENT) ? fpm_pkg::FPM_ALM_PARERR
                                                           : alm_q - 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= fpm_pkg::FPM_MODE_STATUS;
         item_q <= fpm_pkg::FPM_ITEM_RST;
         val_q  <= 1'b0;
         alm_q  <= fpm_pkg::FPM_ALM_CURRENT;
      end else begin
         mode_q <= mode_d;
         item_q <= item_d;
         val_q  <= val_d;
         alm_q  <= alm_d;
      end
   end

   // ----------------------------------------------------------------
   // Display selection
   // ----------------------------------------------------------------
   logic [34:0] segs_d;
   logic [34:0] segs_q;

   always_comb begin
      if (po_q == fpm_pkg::FPM_PO_AXIS) begin
         segs_d = (settle_q == 2'h3) ? axis_segs_i : '0;
      end else if (mode_q != fpm_pkg::FPM_MODE_STATUS) begin
         segs_d = mode_segs_i;
      end else if (val_q) begin
         segs_d = value_segs_i;
      end else begin
         segs_d = symbol_segs_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         segs_q <= '0;
      end else begin
         segs_q <= segs_d;
      end
   end

   assign segs_o       = segs_q;
   assign mode_o       = mode_q;
   assign item_o       = item_q;
   assign show_value_o = val_q;
   assign show_axis_o  = (po_q == fpm_pkg::FPM_PO_AXIS) && (settle_q == 2'h3);
   assign alarm_view_o = alm_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   mode_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && p_mode && mode_q == fpm_pkg::FPM_MODE_TUNE)
      |=> mode_q == fpm_pkg::FPM_MODE_DIAG) else $error("mode did not step");
   ptable_skip_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!ptable_on && $changed(ctrl_s2_q) == 1'b0 && $changed(mode_q))
      |-> mode_q != fpm_pkg::FPM_MODE_PTABLE) else $error("point table mode shown");
   start_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      booting |-> mode_q == fpm_pkg::FPM_MODE_STATUS) else $error("not in status at boot");
   axis_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (settle_q == 2'h2 && axis_s2_q) |=> show_axis_o ##1 (segs_q == $past(axis_segs_i)))
      else $error("axis name not first");
   segs_drive_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && val_q && mode_q == fpm_pkg::FPM_MODE_STATUS)
      |=> segs_q == $past(value_segs_i)) else $error("value not displayed");
   item_up_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && p_up && !p_mode && mode_q == fpm_pkg::FPM_MODE_STATUS
       && item_q < 5'(ITEMS - 1)) |=> item_q == $past(item_q) + 5'h01) else $error("up failed");
   symbol_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && (p_up || p_down) && !p_mode && mode_q == fpm_pkg::FPM_MODE_STATUS)
      |=> !val_q) else $error("symbol not shown");
   set_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && p_set && !p_up && !p_down && !p_mode && mode_q == fpm_pkg::FPM_MODE_STATUS)
      |=> val_q) else $error("set ignored");
   boot_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (po_q == fpm_pkg::FPM_PO_SYMBOL && tmr_q == TW'(SYMBOL_CYC - 1))
      |=> val_q && !booting) else $error("boot value missing");
   alarm_view_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      alm_q != fpm_pkg::FPM_ALM_VIEWS) else $error("bad alarm view");
   wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!booting && p_mode && mode_q == fpm_pkg::FPM_MODE_POS)
      |=> mode_q == fpm_pkg::FPM_MODE_STATUS) else $error("no wrap");

   boot_done_c: cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(booting));
   wrap_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
      !booting && p_mode && mode_q == fpm_pkg::FPM_MODE_POS);
   ptable_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
      mode_q == fpm_pkg::FPM_MODE_PTABLE);
   set_c: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(val_q) && !booting);

endmodule

// [dv/fpm_operator.sv]
// ----------------------------------------------------------------
// Operator at the front panel: presses one button with contact bounce
// ----------------------------------------------------------------
module fpm_operator (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [1:0] which_i,
   input  wire logic       short_i,
   output logic            btn_mode_o,
   output logic            btn_up_o,
   output logic            btn_down_o,
   output logic            btn_set_o,
   output logic            busy_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] btn;

   assign btn_mode_o = btn[0];
   assign btn_up_o   = btn[1];
   assign btn_down_o = btn[2];
   assign btn_set_o  = btn[3];

   // Bounce pulses on make and break are one cycle, well under the debounce
   // window, so a real press must still count once only
   task automatic run(input logic [1:0] w, input logic s);
      int i;
      #1 busy_o = 1'b1;
      btn[w] = 1'b1;
      @(posedge clk_i) #1 btn[w] = 1'b0;
      @(posedge clk_i) #1 btn[w] = 1'b1;
      for (i = 0; i < (s ? 0 : 12); i++) @(posedge clk_i);
      #1 btn[w] = 1'b0;
      @(posedge clk_i) #1 btn[w] = 1'b1;
      @(posedge clk_i) #1 btn[w] = 1'b0;
      for (i = 0; i < 12; i++) @(posedge clk_i);
      #1 busy_o = 1'b0;
   endtask

   // One process owns the buttons and busy, so nothing has two drivers
   initial begin
      btn    = 4'h0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i && !busy_o) run(which_i, short_i);
      end
   end
endmodule

// [dv/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned ITEMS             = 12;
   localparam int unsigned SYM               = 20;
   localparam int unsigned AXC               = 20;
   localparam logic [34:0] AX_SEG            = 35'h0_0000_0A11;
   localparam logic [34:0] SY_SEG            = 35'h0_0000_0B22;
   localparam logic [34:0] VA_SEG            = 35'h0_0000_0C33;
   localparam logic [34:0] MO_SEG            = 35'h0_0000_0D44;
   localparam logic [1:0]  FPM_CTRL_PTABLE_V = fpm_pkg::FPM_CTRL_PTABLE;

   logic        clk_i    = 1'b0;
   logic        rstn_i   = 1'b0;
   logic [1:0]  ctrl     = 2'h0;
   logic        axis_set = 1'b0;
   logic [4:0]  param    = 5'h00;
   logic        go       = 1'b0;
   logic [1:0]  which    = 2'h0;
   logic        short_p  = 1'b0;
   logic        b_mode;
   logic        b_up;
   logic        b_down;
   logic        b_set;
   logic        busy;
   logic [3:0]  mode_o;
   logic [4:0]  item_o;
   logic        show_value_o;
   logic        show_axis_o;
   logic [1:0]  alarm_view_o;
   logic [34:0] segs_o;
   int          n_fail   = 0;
   int          compares = 0;

   always #25 clk_i = ~clk_i;

   fpm_operator op (.clk_i(clk_i), .go_i(go), .which_i(which), .short_i(short_p),
      .btn_mode_o(b_mode), .btn_up_o(b_up), .btn_down_o(b_down), .btn_set_o(b_set),
      .busy_o(busy));

   fpm_menu #(.ITEMS(ITEMS), .SYMBOL_CYC(SYM), .AXIS_CYC(AXC), .DEBOUNCE_CYC(4)) uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .btn_mode_i(b_mode), .btn_up_i(b_up),
      .btn_down_i(b_down), .btn_set_i(b_set), .ctrl_method_i(ctrl),
      .axis_name_set_i(axis_set), .power_on_status_item_param_i(param),
      .axis_segs_i(AX_SEG), .symbol_segs_i(SY_SEG), .value_segs_i(VA_SEG),
      .mode_segs_i(MO_SEG), .mode_o(mode_o), .item_o(item_o),
      .show_value_o(show_value_o), .show_axis_o(show_axis_o),
      .alarm_view_o(alarm_view_o), .segs_o(segs_o));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic timed_out;
      n_fail++;
      $display("Error at %0t: wait ran out", $time);
      finish_test();
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Stimulus goes out 1 ns after an edge; the operator raises busy a cycle later
   task automatic press(input logic [1:0] w, input logic s);
      int n;
      tick(1);
      which = w;
      short_p = s;
      go = 1'b1;
      n = 0;
      while (busy !== 1'b1) begin
         tick(1);
         if (++n > 10) timed_out();
      end
      go = 1'b0;
      while (busy !== 1'b0) begin
         tick(1);
         if (++n > 100) timed_out();
      end
      tick(2);
   endtask

   // Strap phase is not part of the axis phase; symbol time is counted after it only with an axis name, else from reset
   task automatic boot(input logic [1:0] c, input logic ax, input logic [4:0] p);
      int n, na, ns;
      logic [34:0] seg_mid;
      logic [4:0] item_mid;
      rstn_i = 1'b0;
      ctrl = c;
      axis_set = ax;
      param = p;
      tick(4);
      rstn_i = 1'b1;
      n = 0;
      na = 0;
      ns = 0;
      seg_mid = '0;
      item_mid = '0;
      while (show_value_o !== 1'b1) begin
         tick(1);
         if (++n > 200) timed_out();
         if (show_axis_o === 1'b1) begin
            na++;
            if (na == 10) seg_mid = segs_o;
         end else if (!ax || na > 0) begin
            ns++;
            if (ns == 10) begin
               check(segs_o, SY_SEG);
               item_mid = item_o;
            end
         end
      end
      check(35'(na >= AXC - 1 && na <= AXC + 1), 35'(ax));
      if (ax) check(seg_mid, AX_SEG);
      check(35'(ns >= SYM - 1 && ns <= SYM + 4), 35'h1);
      check(35'(item_mid), 35'(p >= ITEMS ? 5'h00 : p));
      tick(2);
      check(segs_o, VA_SEG);
      check(35'(mode_o), 35'h0);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_modes(input logic [1:0] c);
      int cur, nxt, k;
      cur = 0;
      k = 0;
      do begin
         press(2'h0, 1'b0);
         nxt = (cur == 11) ? 0 : cur + 1;
         if (nxt == 4 && c != FPM_CTRL_PTABLE_V) nxt = 5;
         check(35'(mode_o), 35'(nxt));
         check(segs_o, nxt == 0 ? SY_SEG : MO_SEG);
         cur = nxt;
         k++;
      end while (cur != 0 && k < 13);
      check(35'(k), c == FPM_CTRL_PTABLE_V ? 35'h0C : 35'h0B);
   endtask

   task automatic t_alarm;
      repeat (3) press(2'h0, 1'b0);
      check(35'(mode_o), 35'(fpm_pkg::FPM_MODE_ALARM));
      check(35'(alarm_view_o), 35'(fpm_pkg::FPM_ALM_CURRENT));
      press(2'h1, 1'b0);
      check(35'(alarm_view_o), 35'(fpm_pkg::FPM_ALM_HISTORY));
      press(2'h1, 1'b0);
      check(35'(alarm_view_o), 35'(fpm_pkg::FPM_ALM_PARERR));
      press(2'h1, 1'b0);
      check(35'(alarm_view_o), 35'(fpm_pkg::FPM_ALM_CURRENT));
      press(2'h2, 1'b0);
      check(35'(alarm_view_o), 35'(fpm_pkg::FPM_ALM_PARERR));
      check(35'(item_o), 35'h3);
      press(2'h3, 1'b0);
      check(35'(show_value_o), 35'h0);
      check(segs_o, MO_SEG);
   endtask

   task automatic t_status;
      press(2'h1, 1'b0);
      check(35'(item_o), 35'h1);
      check(35'(show_value_o), 35'h0);
      check(segs_o, SY_SEG);
      press(2'h3, 1'b0);
      check(35'(show_value_o), 35'h1);
      check(segs_o, VA_SEG);
      press(2'h2, 1'b0);
      check(35'(item_o), 35'h0);
      check(segs_o, SY_SEG);
      press(2'h2, 1'b0);
      check(35'(item_o), 35'(ITEMS - 1));
   endtask

   // A glitch must be ignored, a bouncing press must step exactly once
   task automatic t_glitch;
      press(2'h1, 1'b1);
      check(35'(item_o), 35'(ITEMS - 1));
      press(2'h1, 1'b0);
      check(35'(item_o), 35'h0);
      check(35'(mode_o), 35'h0);
   endtask

   initial begin
      boot(2'h0, 1'b1, 5'h03);
      t_modes(2'h0);
      t_alarm();
      boot(2'h1, 1'b0, 5'h05);
      check(35'(item_o), 35'h5);
      boot(2'h2, 1'b0, 5'h1F);
      t_status();
      t_glitch();
      t_modes(2'h2);
      finish_test();
   end
endmodule
